//--- include/ishi_pkg.sv
package ishi_pkg;

	// register map
	localparam logic [5:0] REG_SERIAL_CFG     = 6'h16;
	localparam logic [7:0] SERIAL_CFG_RESET   = 8'h00;
	localparam int         CFG_HALF_DUPLEX    = 0;
	localparam int         CFG_I2C_DISABLE    = 1;
	localparam int         CFG_PARITY_SEL     = 2;
	localparam int         CFG_GLITCH_FILTER  = 3;
	localparam int         CFG_HOLD_DELAY     = 4;

	// i2c slave address, upper six bits
	localparam logic [5:0] I2C_BASE_ADDR      = 6'h2c;
	localparam logic [3:0] I2C_BYTE_BITS      = 4'h8;

	// spi frame bit positions
	localparam logic [3:0] SPI_CMD_LAST_BIT   = 4'h7;
	localparam logic [3:0] SPI_DATA_FIRST_BIT = 4'h8;
	localparam logic [3:0] SPI_FRAME_LAST_BIT = 4'hf;

	// link rate limits
	localparam int         SPI_MAX_HZ         = 10_000_000;
	localparam int         I2C_MAX_HZ         = 3_400_000;

	// timing
	localparam int         MCLK_PERIOD_NS     = 10;
	localparam int         GLITCH_FILTER_NS   = 50;
	localparam logic [2:0] GLITCH_FILTER_CYC  = 3'((GLITCH_FILTER_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS);
	localparam int         HOLD_DELAY_NS      = 30;
	localparam logic [2:0] HOLD_DELAY_CYC     = 3'((HOLD_DELAY_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS);

	typedef enum logic [2:0] {
		I2C_IDLE  = 3'h0,
		I2C_ADDR  = 3'h1,
		I2C_ACK   = 3'h2,
		I2C_WBYTE = 3'h3,
		I2C_RBYTE = 3'h4,
		I2C_RACK  = 3'h5
	} ishi_i2c_state_type;

endpackage : ishi_pkg

//--- include/ishi_mem_if.sv
`timescale 1ns/1ps
interface ishi_mem_if;
	logic       wrEn;
	logic [5:0] wrAddr;
	logic [7:0] wrData;
	logic       rdEn;
	logic [5:0] rdAddr;
	logic [7:0] rdData;

	modport access (output wrEn, output wrAddr, output wrData, output rdEn, output rdAddr, input rdData);
	modport store  (input wrEn, input wrAddr, input wrData, input rdEn, input rdAddr, output rdData);
endinterface : ishi_mem_if

//--- verilog/ishi_reg_mem.sv
`timescale 1ns/1ps
module ishi_reg_mem (
	// system
	input wire logic  mclk,
	input wire logic  reset_n,
	// access port
	ishi_mem_if.store bus
);

	logic [7:0] cells [0:63];

	// no reset on the array: contents are undefined until written
	always_ff @(posedge mclk) begin
		if (bus.wrEn) begin
			cells[bus.wrAddr] <= bus.wrData;
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			bus.rdData <= 8'h00;
		end else if (bus.rdEn) begin
			bus.rdData <= cells[bus.rdAddr];
		end
	end

endmodule : ishi_reg_mem

//--- verilog/ishi_top.sv
// Summary of operation
// - chip select high selects the i2c slave, low selects the spi slave.
// - i2c address is six fixed upper bits plus the address-select pin level.
// - address-select low answers 1011000, high answers 1011001.
// - acknowledge only a matching address; otherwise leave the bus released.
// - i2c logic keeps up with high-speed transfers up to 3.4 MHz.
// - i2c disable bit in the config register blocks i2c mode on bus traffic.
// - spi slave runs up to 10 MHz in three-wire and four-wire form.
// - single access takes 16 clocks; each further burst byte adds 8.
// - bits start on falling edges; bit 0 at first fall after select.
// - frame bit 0 is direction, 1 reads; read data driven from bit 8.
// - frame bit 1 is address hold or address parity, by parity select.
// - frame bits 2 to 7 carry the six-bit register index.
// - write frame bits 8 to 15 carry the byte to store, msb first.
// - read frame bits 8 to 15 shift out the register byte, msb first.
// - half-duplex select bit: 0 full-duplex, 1 half-duplex; full-duplex after reset.
// - half-duplex uses the one bidirectional data pin both ways.
// - full-duplex shifts 8 output bits out during the command byte.
// - i2c clock and data have selectable glitch filter and output hold delay.
// - chip select high leaves the spi data output undriven.
`timescale 1ns/1ps
module ishi_top (
	// system
	input  wire logic mclk,
	input  wire logic reset_n,
	// serial clock and select
	input  wire logic linkClk,
	input  wire logic csN,
	// shared data pin
	input  wire logic sdaIn,
	output      logic sdaOut,
	output      logic sdaDriveN,
	// data out / address select pin
	input  wire logic addrSelIn,
	output      logic sdoOut,
	output      logic sdoDriveN
);

	typedef struct packed {
		logic [3:0] bitCnt;
		logic       cmdDone;
		logic       isRead;
		logic       holdAddr;
		logic       parityOk;
		logic [5:0] curAddr;
		logic [6:0] shiftIn;
	} ishi_spi_frame_type;

	typedef struct packed {
		logic       wrTog;
		logic [5:0] wrAddr;
		logic [7:0] wrData;
		logic       rdTog;
		logic [5:0] rdAddr;
		logic [7:0] cfgMeta;
		logic [7:0] cfgSync;
	} ishi_spi_keep_type;

	typedef struct packed {
		logic [3:0] fallCnt;
		logic [7:0] outShift;
		logic       sdoDrvN;
		logic       sdaDrvN;
		logic       halfLatch;
	} ishi_spi_out_type;

	typedef struct packed {
		logic [1:0]              csSync;
		logic [1:0]              sclSync;
		logic [1:0]              sdaSync;
		logic [1:0]              selSync;
		logic [1:0]              wrSync;
		logic [1:0]              rdSync;
		logic                    wrSeen;
		logic                    rdSeen;
		logic [7:0]              cfg;
		logic                    rdStage;
		logic                    rdIsCfg;
		logic [7:0]              rdByte;
		logic                    sclF;
		logic                    sdaF;
		logic                    sclPrev;
		logic                    sdaPrev;
		logic [2:0]              sclCnt;
		logic [2:0]              sdaCnt;
		ishi_pkg::ishi_i2c_state_type st;
		logic [3:0]              bitCnt;
		logic [7:0]              shift;
		logic                    isRead;
		logic                    ptrLoaded;
		logic [5:0]              regPtr;
		logic                    drvWant;
		logic                    drvN;
		logic [2:0]              holdCnt;
	} ishi_main_type;

	localparam ishi_main_type MAIN_RESET = '{
		csSync: 2'h3, sclSync: 2'h3, sdaSync: 2'h3,
		cfg: ishi_pkg::SERIAL_CFG_RESET,
		sclF: 1'b1, sdaF: 1'b1, sclPrev: 1'b1, sdaPrev: 1'b1,
		st: ishi_pkg::I2C_IDLE,
		drvWant: 1'b1, drvN: 1'b1,
		default: '0
	};
	localparam ishi_spi_out_type OUT_RESET = '{sdoDrvN: 1'b1, sdaDrvN: 1'b1, default: '0};

	ishi_spi_frame_type fr_r, fr_nxt;
	ishi_spi_keep_type  kp_r, kp_nxt;
	ishi_spi_out_type   fl_r, fl_nxt;
	ishi_main_type      m_r, m_nxt;

	ishi_mem_if memBus ();

	ishi_reg_mem u_mem (
		.mclk    (mclk),
		.reset_n (reset_n),
		.bus     (memBus.store)
	);

	function automatic logic ishi_is_cfg(input logic [5:0] addr);
		return addr == ishi_pkg::REG_SERIAL_CFG;
	endfunction : ishi_is_cfg

	// returns {filtered level, stable count}
	function automatic logic [3:0] ishi_filter(input logic raw, input logic cur, input logic [2:0] cnt,
		input logic en);
		logic [3:0] res;
		res = {raw, 3'h0};
		if (en) begin
			if (raw == cur) begin
				res = {cur, 3'h0};
			end else if (cnt != ishi_pkg::GLITCH_FILTER_CYC - 3'h1) begin
				res = {cur, cnt + 3'h1};
			end
		end
		return res;
	endfunction : ishi_filter

	function automatic logic [3:0] ishi_next_bit(input logic [3:0] cnt);
		return (cnt == ishi_pkg::SPI_FRAME_LAST_BIT) ? ishi_pkg::SPI_DATA_FIRST_BIT : cnt + 4'h1;
	endfunction : ishi_next_bit

	// spi, rising edges of the link clock: sampling side
	always_comb begin
		logic [7:0] byteIn;
		logic       parityMode;
		logic [5:0] stepAddr;
		byteIn     = {fr_r.shiftIn, sdaIn};
		parityMode = kp_r.cfgSync[ishi_pkg::CFG_PARITY_SEL];
		stepAddr   = fr_r.curAddr + (fr_r.holdAddr ? 6'h00 : 6'h01);
		fr_nxt         = fr_r;
		kp_nxt         = kp_r;
		kp_nxt.cfgMeta = m_r.cfg;
		kp_nxt.cfgSync = kp_r.cfgMeta;
		fr_nxt.shiftIn = byteIn[6:0];
		fr_nxt.bitCnt  = ishi_next_bit(fr_r.bitCnt);
		if (fr_r.bitCnt == ishi_pkg::SPI_CMD_LAST_BIT) begin
			fr_nxt.cmdDone  = 1'b1;
			fr_nxt.isRead   = byteIn[7];
			fr_nxt.holdAddr = byteIn[6] & ~parityMode;
			fr_nxt.curAddr  = byteIn[5:0];
			fr_nxt.parityOk = ~parityMode | (byteIn[6] == ^byteIn[5:0]);
			if (byteIn[7] && (~parityMode || byteIn[6] == ^byteIn[5:0])) begin
				kp_nxt.rdTog  = ~kp_r.rdTog;
				kp_nxt.rdAddr = byteIn[5:0];
			end
		end else if (fr_r.cmdDone && fr_r.parityOk) begin
			// prefetch the next burst byte well before its first falling edge
			if (fr_r.isRead && fr_r.bitCnt == ishi_pkg::SPI_DATA_FIRST_BIT) begin
				fr_nxt.curAddr = stepAddr;
				kp_nxt.rdTog   = ~kp_r.rdTog;
				kp_nxt.rdAddr  = stepAddr;
			end
			if (!fr_r.isRead && fr_r.bitCnt == ishi_pkg::SPI_FRAME_LAST_BIT) begin
				kp_nxt.wrTog   = ~kp_r.wrTog;
				kp_nxt.wrAddr  = fr_r.curAddr;
				kp_nxt.wrData  = byteIn;
				fr_nxt.curAddr = stepAddr;
			end
		end
	end

	// frame state clears while deselected, so each frame starts from bit 0
	always_ff @(posedge linkClk or posedge csN or negedge reset_n) begin
		if (!reset_n || csN) begin
			fr_r <= '0;
		end else begin
			fr_r <= fr_nxt;
		end
	end

	// toggles must survive deselect, or a reset would look like an event
	always_ff @(posedge linkClk or negedge reset_n) begin
		if (!reset_n) begin
			kp_r <= '{cfgMeta: ishi_pkg::SERIAL_CFG_RESET, cfgSync: ishi_pkg::SERIAL_CFG_RESET, default: '0};
		end else begin
			kp_r <= kp_nxt;
		end
	end

	// spi, falling edges of the link clock: driving side
	always_comb begin
		logic halfDuplex;
		// mode frozen at bit 0 so a frame never swaps pins halfway
		halfDuplex      = (fl_r.fallCnt == 4'h0) ? kp_r.cfgSync[ishi_pkg::CFG_HALF_DUPLEX]
			: fl_r.halfLatch;
		fl_nxt          = fl_r;
		fl_nxt.halfLatch = halfDuplex;
		fl_nxt.fallCnt  = ishi_next_bit(fl_r.fallCnt);
		fl_nxt.outShift = {fl_r.outShift[6:0], 1'b0};
		if (fl_r.fallCnt == 4'h0 && !halfDuplex) begin
			// config snapshot fills the command phase in four-wire form
			fl_nxt.outShift = kp_r.cfgSync;
			fl_nxt.sdoDrvN  = 1'b0;
		end
		if (fl_r.fallCnt == ishi_pkg::SPI_DATA_FIRST_BIT) begin
			fl_nxt.outShift = (fr_r.isRead && fr_r.parityOk) ? m_r.rdByte : 8'h00;
			if (halfDuplex) begin
				fl_nxt.sdoDrvN = 1'b1;
				fl_nxt.sdaDrvN = ~(fr_r.isRead & fr_r.parityOk);
			end else begin
				fl_nxt.sdoDrvN = 1'b0;
			end
		end
	end

	always_ff @(negedge linkClk or posedge csN or negedge reset_n) begin
		if (!reset_n || csN) begin
			fl_r <= OUT_RESET;
		end else begin
			fl_r <= fl_nxt;
		end
	end

	// system clock side: i2c engine, register store, spi crossing
	always_comb begin
		logic sclRise;
		logic sclFall;
		logic startC;
		logic stopC;
		logic i2cOn;
		logic spiWr;
		logic spiRd;
		sclRise = m_r.sclF & ~m_r.sclPrev;
		sclFall = ~m_r.sclF & m_r.sclPrev;
		startC  = m_r.sclF & m_r.sclPrev & m_r.sdaPrev & ~m_r.sdaF;
		stopC   = m_r.sclF & m_r.sclPrev & ~m_r.sdaPrev & m_r.sdaF;
		i2cOn   = m_r.csSync[1] & ~m_r.cfg[ishi_pkg::CFG_I2C_DISABLE];
		spiWr   = m_r.wrSync[1] ^ m_r.wrSeen;
		spiRd   = m_r.rdSync[1] ^ m_r.rdSeen;

		m_nxt          = m_r;
		memBus.wrEn    = 1'b0;
		memBus.wrAddr  = 6'h00;
		memBus.wrData  = 8'h00;
		memBus.rdEn    = 1'b0;
		memBus.rdAddr  = 6'h00;
		m_nxt.csSync   = {m_r.csSync[0], csN};
		m_nxt.sclSync  = {m_r.sclSync[0], linkClk};
		m_nxt.sdaSync  = {m_r.sdaSync[0], sdaIn};
		m_nxt.selSync  = {m_r.selSync[0], addrSelIn};
		m_nxt.wrSync   = {m_r.wrSync[0], kp_r.wrTog};
		m_nxt.rdSync   = {m_r.rdSync[0], kp_r.rdTog};
		m_nxt.wrSeen   = m_r.wrSync[1];
		m_nxt.rdSeen   = m_r.rdSync[1];
		{m_nxt.sclF, m_nxt.sclCnt} = ishi_filter(m_r.sclSync[1], m_r.sclF, m_r.sclCnt,
			m_r.cfg[ishi_pkg::CFG_GLITCH_FILTER]);
		{m_nxt.sdaF, m_nxt.sdaCnt} = ishi_filter(m_r.sdaSync[1], m_r.sdaF, m_r.sdaCnt,
			m_r.cfg[ishi_pkg::CFG_GLITCH_FILTER]);
		m_nxt.sclPrev  = m_r.sclF;
		m_nxt.sdaPrev  = m_r.sdaF;
		m_nxt.rdStage  = 1'b0;
		if (m_r.rdStage) begin
			m_nxt.rdByte = m_r.rdIsCfg ? m_r.cfg : memBus.rdData;
		end

		// 100 MHz oversampling leaves many samples per bit even at 3.4 MHz
		if (!i2cOn) begin
			m_nxt.st      = ishi_pkg::I2C_IDLE;
			m_nxt.drvWant = 1'b1;
		end else if (startC) begin
			m_nxt.st        = ishi_pkg::I2C_ADDR;
			m_nxt.bitCnt    = 4'h0;
			m_nxt.ptrLoaded = 1'b0;
			m_nxt.drvWant   = 1'b1;
		end else if (stopC) begin
			m_nxt.st      = ishi_pkg::I2C_IDLE;
			m_nxt.drvWant = 1'b1;
		end else begin
			case (m_r.st)
				ishi_pkg::I2C_ADDR, ishi_pkg::I2C_WBYTE: begin
					if (sclRise) begin
						m_nxt.shift  = {m_r.shift[6:0], m_r.sdaF};
						m_nxt.bitCnt = m_r.bitCnt + 4'h1;
					end
					if (sclFall && m_r.bitCnt == ishi_pkg::I2C_BYTE_BITS) begin
						m_nxt.st      = ishi_pkg::I2C_ACK;
						m_nxt.drvWant = 1'b0;
						if (m_r.st == ishi_pkg::I2C_ADDR) begin
							if (m_r.shift[7:1] == {ishi_pkg::I2C_BASE_ADDR, m_r.selSync[1]}) begin
								m_nxt.isRead = m_r.shift[0];
								if (m_r.shift[0]) begin
									memBus.rdEn   = 1'b1;
									memBus.rdAddr = m_r.regPtr;
								end
							end else begin
								m_nxt.st      = ishi_pkg::I2C_IDLE;
								m_nxt.drvWant = 1'b1;
							end
						end else if (!m_r.ptrLoaded) begin
							m_nxt.regPtr    = m_r.shift[5:0];
							m_nxt.ptrLoaded = 1'b1;
						end else begin
							memBus.wrEn   = 1'b1;
							memBus.wrAddr = m_r.regPtr;
							memBus.wrData = m_r.shift;
							m_nxt.regPtr  = m_r.regPtr + 6'h01;
						end
					end
				end
				ishi_pkg::I2C_ACK, ishi_pkg::I2C_RACK: begin
					if (sclRise && m_r.st == ishi_pkg::I2C_RACK && m_r.sdaF) begin
						m_nxt.st = ishi_pkg::I2C_IDLE;
					end
					if (sclFall) begin
						m_nxt.bitCnt = 4'h0;
						if (m_r.isRead) begin
							m_nxt.st      = ishi_pkg::I2C_RBYTE;
							m_nxt.drvWant = m_r.rdByte[7];
							m_nxt.shift   = {m_r.rdByte[6:0], 1'b1};
							m_nxt.regPtr  = m_r.regPtr + 6'h01;
							memBus.rdEn   = 1'b1;
							memBus.rdAddr = m_r.regPtr + 6'h01;
						end else begin
							m_nxt.st      = ishi_pkg::I2C_WBYTE;
							m_nxt.drvWant = 1'b1;
						end
					end
				end
				ishi_pkg::I2C_RBYTE: begin
					if (sclRise) begin
						m_nxt.bitCnt = m_r.bitCnt + 4'h1;
					end
					if (sclFall) begin
						if (m_r.bitCnt == ishi_pkg::I2C_BYTE_BITS) begin
							m_nxt.st      = ishi_pkg::I2C_RACK;
							m_nxt.drvWant = 1'b1;
						end else begin
							m_nxt.drvWant = m_r.shift[7];
							m_nxt.shift   = {m_r.shift[6:0], 1'b1};
						end
					end
				end
				default: begin
					m_nxt.st = ishi_pkg::I2C_IDLE;
				end
			endcase
		end

		// spi accesses take the port over; the two modes never overlap
		if (spiWr) begin
			memBus.wrEn   = 1'b1;
			memBus.wrAddr = kp_r.wrAddr;
			memBus.wrData = kp_r.wrData;
		end
		if (spiRd) begin
			memBus.rdEn   = 1'b1;
			memBus.rdAddr = kp_r.rdAddr;
		end
		if (memBus.wrEn && ishi_is_cfg(memBus.wrAddr)) begin
			m_nxt.cfg = memBus.wrData;
		end
		if (memBus.rdEn) begin
			m_nxt.rdStage = 1'b1;
			m_nxt.rdIsCfg = ishi_is_cfg(memBus.rdAddr);
		end

		// delay after a clock fall keeps data hold time on the bus
		if (sclFall) begin
			m_nxt.holdCnt = m_r.cfg[ishi_pkg::CFG_HOLD_DELAY] ? ishi_pkg::HOLD_DELAY_CYC : 3'h0;
		end else if (m_r.holdCnt != 3'h0) begin
			m_nxt.holdCnt = m_r.holdCnt - 3'h1;
		end else begin
			m_nxt.drvN = m_nxt.drvWant;
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			m_r <= MAIN_RESET;
		end else begin
			m_r <= m_nxt;
		end
	end

	assign sdoOut    = fl_r.outShift[7];
	assign sdaOut    = fl_r.outShift[7];
	assign sdoDriveN = fl_r.sdoDrvN;
	assign sdaDriveN = fl_r.sdaDrvN & m_r.drvN;

endmodule : ishi_top

//--- testbench/ishi_monitor.sv
`timescale 1ns/1ps
module ishi_monitor (
	// system
	input wire logic mclk,
	input wire logic reset_n,
	// link
	input wire logic linkClk,
	input wire logic csN,
	input wire logic sdaOut,
	input wire logic sdaDriveN,
	input wire logic sdoOut,
	input wire logic sdoDriveN
);
	logic [7:0] riseCnt;

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!reset_n);

	// saturates so long bursts never wrap back below 8
	always_ff @(posedge linkClk or posedge csN) begin
		if (csN) begin
			riseCnt <= 8'h00;
		end else if (riseCnt != 8'hff) begin
			riseCnt <= riseCnt + 8'h01;
		end
	end

	a_reset_quiet: assert property ($rose(reset_n) |-> sdoDriveN && sdaDriveN && !sdoOut)
		else $error("pins driven after reset");
	a_sdo_deselect: assert property (csN && $past(csN) |-> sdoDriveN && !sdoOut)
		else $error("data out active while deselected");
	a_sdo_release: assert property ($rose(sdoDriveN) |-> csN)
		else $error("data out released inside a frame");
	a_sdo_start: assert property (!csN && $fell(sdoDriveN) |-> !linkClk && riseCnt == 8'h00)
		else $error("data out not driven from bit 0");
	a_sda_start: assert property (!csN && $fell(sdaDriveN) |-> !linkClk && riseCnt == 8'h08)
		else $error("read drive not at bit 8");
	a_sda_window: assert property (!csN && !sdaDriveN |-> riseCnt >= 8'h08)
		else $error("data pin driven in command phase");
	a_sda_stands: assert property (!csN && !sdaDriveN |=> csN || !sdaDriveN)
		else $error("data pin dropped inside a read");
	a_sdo_on_fall: assert property (!csN && !$past(csN) && $changed(sdoOut) |-> !linkClk)
		else $error("data out changed off the falling edge");
	a_sda_on_fall: assert property (!csN && linkClk && $past(linkClk) |-> $stable(sdaOut))
		else $error("data pin changed while clock high");
endmodule : ishi_monitor

bind ishi_top ishi_monitor mon (
	.mclk      (mclk),
	.reset_n   (reset_n),
	.linkClk   (linkClk),
	.csN       (csN),
	.sdaOut    (sdaOut),
	.sdaDriveN (sdaDriveN),
	.sdoOut    (sdoOut),
	.sdoDriveN (sdoDriveN)
);

//--- testbench/ishi_spi_master.sv
`timescale 1ns/1ps
module ishi_spi_master (
	// link pins
	output logic linkClk,
	output logic csN,
	output logic mBit,
	output logic mDriveN,
	// sensed lines
	input  wire logic sdaLine,
	input  wire logic sdoLine
);
	initial begin
		linkClk = 1'b1;
		csN     = 1'b1;
		mBit    = 1'b1;
		mDriveN = 1'b0;
	end

	// msb of tx goes first; odd start offset keeps link edges off mclk edges
	task automatic xfer(input int nb, input logic [31:0] tx, input bit hd, output logic [31:0] rx);
		rx = '0;
		#3.3;
		linkClk = 1'b1;
		csN = 1'b0;
		#62.5;
		for (int i = 0; i < 8 * nb; i++) begin
			linkClk = 1'b0;
			mDriveN = hd && tx[31] && i >= 8;
			mBit = tx[31 - i];
			#62.5;
			rx[31 - i] = hd ? sdaLine : sdoLine;
			linkClk = 1'b1;
			#62.5;
		end
		csN = 1'b1;
		mDriveN = 1'b0;
		mBit = 1'b1;
		#600;
	endtask : xfer
endmodule : ishi_spi_master

//--- testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
	logic        mclk;
	logic        reset_n;
	logic        addrSel;
	logic        sdoUsed;
	logic        sdaOut;
	logic        sdaDriveN;
	logic        sdoOut;
	logic        sdoDriveN;
	logic        linkClk;
	logic        csN;
	logic        mBit;
	logic        mDriveN;
	logic        sdaLine;
	logic        sdoLine;
	logic [31:0] rx;
	int          failures = 0;
	int          checked = 0;
	int          cycles = 0;

	// pull-up on data; address strap shows when data out floats
	assign sdaLine = !sdaDriveN ? sdaOut : (!mDriveN ? mBit : 1'b1);
	assign sdoLine = !sdoDriveN ? sdoOut : addrSel;

	ishi_spi_master master (
		.linkClk (linkClk),
		.csN     (csN),
		.mBit    (mBit),
		.mDriveN (mDriveN),
		.sdaLine (sdaLine),
		.sdoLine (sdoLine)
	);

	ishi_top dut (
		.mclk      (mclk),
		.reset_n   (reset_n),
		.linkClk   (linkClk),
		.csN       (csN),
		.sdaIn     (sdaLine),
		.sdaOut    (sdaOut),
		.sdaDriveN (sdaDriveN),
		.addrSelIn (sdoLine),
		.sdoOut    (sdoOut),
		.sdoDriveN (sdoDriveN)
	);

	always #5 mclk = ~mclk;

	always @(negedge sdoDriveN) sdoUsed = 1'b1;

	task automatic final_report();
		$display("checked=%0d failures=%0d", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : final_report

	// hang guard, about three times the expected run
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			final_report();
		end
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [5:0] a, input logic ms, input logic [15:0] d, input int nb, input bit hd);
		master.xfer(nb, {1'b0, ms, a, d, 8'h00}, hd, rx);
	endtask : wr

	task automatic rd(input logic [5:0] a, input logic ms, input int nb, input bit hd);
		master.xfer(nb, {1'b1, ms, a, 24'h000000}, hd, rx);
	endtask : rd

	task automatic scn_single();
		logic [5:0] adr [3];
		logic [7:0] dat [3];
		adr = '{6'h05, 6'h3f, 6'h00};
		dat = '{8'ha5, 8'h5a, 8'hc3};
		rd(6'h16, 1'b0, 2, 1'b0);
		chk(rx[23:16], ishi_pkg::SERIAL_CFG_RESET);
		for (int i = 0; i < 3; i++) begin
			wr(adr[i], 1'b0, {dat[i], 8'h00}, 2, 1'b0);
		end
		for (int i = 0; i < 3; i++) begin
			rd(adr[i], 1'b0, 2, 1'b0);
			chk(rx[23:16], dat[i]);
			chk(rx[31:24], 8'h00);
		end
	endtask : scn_single

	task automatic scn_burst();
		wr(6'h10, 1'b0, 16'h1122, 3, 1'b0);
		wr(6'h21, 1'b0, 16'h7700, 2, 1'b0);
		wr(6'h20, 1'b1, 16'h3344, 3, 1'b0);
		rd(6'h10, 1'b0, 3, 1'b0);
		chk(rx[23:16], 8'h11);
		chk(rx[15:8], 8'h22);
		rd(6'h20, 1'b0, 3, 1'b0);
		chk(rx[23:16], 8'h44);
		chk(rx[15:8], 8'h77);
	endtask : scn_burst

	task automatic scn_half();
		wr(6'h16, 1'b0, 16'h0100, 2, 1'b0);
		// new mode is only seen from the frame after one that carries it across
		wr(6'h16, 1'b0, 16'h0100, 2, 1'b0);
		rd(6'h16, 1'b0, 2, 1'b1);
		chk(rx[23:16], 8'h01);
		sdoUsed = 1'b0;
		rd(6'h10, 1'b0, 3, 1'b1);
		chk(rx[23:16], 8'h11);
		chk(rx[15:8], 8'h22);
		chk({7'h00, sdoUsed}, 8'h00);
	endtask : scn_half

	task automatic scn_parity();
		wr(6'h16, 1'b0, 16'h0400, 2, 1'b1);
		wr(6'h16, 1'b1, 16'h0400, 2, 1'b1);
		rd(6'h16, 1'b1, 2, 1'b0);
		chk(rx[23:16], 8'h04);
		wr(6'h05, 1'b1, 16'hff00, 2, 1'b0);
		rd(6'h05, 1'b1, 2, 1'b0);
		chk(rx[23:16], 8'h00);
		rd(6'h05, 1'b0, 2, 1'b0);
		chk(rx[23:16], 8'ha5);
	endtask : scn_parity

	initial begin
		mclk = 1'b0;
		reset_n = 1'b0;
		addrSel = 1'b1;
		sdoUsed = 1'b0;
		repeat (12) @(posedge mclk);
		@(negedge mclk);
		chk({6'h00, sdoDriveN, sdaDriveN}, 8'h03);
		reset_n = 1'b1;
		repeat (6) @(negedge mclk);
		chk({6'h00, sdoDriveN, sdaDriveN}, 8'h03);
		scn_single();
		scn_burst();
		scn_half();
		scn_parity();
		final_report();
	end
endmodule : testbench
